// file: rtl/swc_pkg.sv
/*
 * Package for the selective-wake configuration bank: register addresses,
 * field positions, reset values and the unlock code.
 * Assumes an 8-bit register port with 7-bit addresses from the serial front end.
 */
package swc_pkg;
    localparam logic [6:0] ADDR_CTRL     = 7'h20;
    localparam logic [6:0] ADDR_QUANTA   = 7'h21;
    localparam logic [6:0] ADDR_SAMPLE   = 7'h22;
    localparam logic [6:0] ADDR_ID_HIGH  = 7'h23;
    localparam logic [6:0] ADDR_ID_MIDH  = 7'h24;
    localparam logic [6:0] ADDR_ID_MIDL  = 7'h25;
    localparam logic [6:0] ADDR_ID_LOW   = 7'h26;
    localparam logic [6:0] ADDR_OPTION   = 7'h30;

    localparam int         CTRL_CAL_BIT  = 7;
    localparam int         CTRL_UNL_HI   = 6;
    localparam int         CTRL_UNL_LO   = 5;
    localparam int         CTRL_MASK_BIT = 4;
    localparam int         CTRL_VAL_BIT  = 0;
    localparam logic [1:0] UNLOCK_CODE   = 2'h3;

    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] QUANTA_RST    = 8'ha0;
    localparam logic [5:0] SAMPLE_RST    = 6'h33;
    localparam logic [7:0] ID_RST        = 8'h00;
    localparam logic [7:0] OPTION_RST    = 8'h00;
    localparam logic [7:0] SAMPLE_MASK   = 8'h3f;
    localparam logic [7:0] IDLOW_MASK    = 8'h7f;
    localparam logic [7:0] CTRL_RD_MASK  = 8'hf1;
endpackage

// file: rtl/swc_regif.sv
/*
 * Interface carrying one register access from the top to the storage bank.
 * Assumes both ends share clk.
 */
`timescale 1ns/10ps
interface swc_regif;
    logic       wrEn;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output wrEn, output addr, output wdata, input rdata);
    modport slave  (input wrEn, input addr, input wdata, output rdata);
endinterface

// file: rtl/swc_id_bank.sv
/*
 * Storage of the four expected-identifier bytes, registered read data.
 * Assumes one access per cycle from the parent.
 */
`timescale 1ns/10ps
module swc_id_bank
    import swc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  restart,
    input  wire logic  softReset,
    swc_regif.slave    bus,
    output logic [31:0] identWord
);
    logic [7:0] mem_r [4];

    function automatic logic [1:0] slotOf(input logic [6:0] a);
        slotOf = 2'(a - ADDR_ID_HIGH);
    endfunction

    function automatic logic inRange(input logic [6:0] a);
        inRange = (a >= ADDR_ID_HIGH) && (a <= ADDR_ID_LOW);
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gSlot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[g] <= ID_RST;
                end else if (softReset) begin
                    mem_r[g] <= ID_RST;
                end else if (restart && g == 3) begin
                    mem_r[g] <= mem_r[g] & IDLOW_MASK;
                end else if (bus.wrEn && inRange(bus.addr) && slotOf(bus.addr) == 2'(g)) begin
                    mem_r[g] <= (g == 3) ? (bus.wdata & IDLOW_MASK) : bus.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= 8'h00;
        end else begin
            bus.rdata <= inRange(bus.addr) ? mem_r[slotOf(bus.addr)] : 8'h00;
        end
    end

    assign identWord = {mem_r[0], mem_r[1], mem_r[2], mem_r[3]};
endmodule

// file: rtl/swc_config.sv
/*
 * Selective-wake configuration bank: control, bit timing, identifier and
 * option registers, with valid-flag housekeeping and time-out interrupt.
 * Assumes a serial front end on clk presenting one-cycle write strobes and
 * read addresses; read data appear one cycle after the address.
 */
`timescale 1ns/10ps
module swc_config
    import swc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        softReset,
    input  wire logic        restart,
    input  wire logic        regWrite,
    input  wire logic [6:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    input  wire logic        wakeUpEvent,
    input  wire logic        busTimeoutEvent,
    input  wire logic        modeNormalOrStop,
    input  wire logic        busTransmitInput,
    output logic             oscCalActive,
    output logic             oscTrimRef,
    output logic             trimUnlocked,
    output logic             selectiveWakeEnable,
    output logic             busTimeoutFlag,
    output logic             interrupt_out_n,
    output logic      [7:0]  quantaPerBit,
    output logic      [5:0]  samplePointFraction,
    output logic      [28:0] identExpected,
    output logic      [10:0] identStandard,
    output logic             remoteRequest,
    output logic             identExtended,
    output logic      [7:0]  wakeOptionReg
);
    logic       oscCal_r;
    logic [1:0] unlock_r;
    logic       toMask_r;
    logic       cfgValid_r;
    logic [7:0] quanta_r;
    logic [5:0] sample_r;
    logic [7:0] option_r;
    logic       toFlag_r;
    logic       irq_r;
    logic [7:0] rdLocal_r;
    logic [31:0] identWord;
    logic       cfgChange;
    logic       ctrlWrite;
    logic       txSync1_r;
    logic       txSync2_r;

    swc_regif idBus ();
    assign idBus.wrEn  = regWrite;
    assign idBus.addr  = regAddr;
    assign idBus.wdata = regWdata;

    swc_id_bank uIdBank (
        .clk       (clk),
        .rst_n     (rst_n),
        .restart   (restart),
        .softReset (softReset),
        .bus       (idBus),
        .identWord (identWord)
    );

    assign ctrlWrite = regWrite && regAddr == ADDR_CTRL;
    assign cfgChange = regWrite && ((regAddr >= ADDR_QUANTA && regAddr <= ADDR_ID_LOW)
                       || (regAddr == ADDR_OPTION && trimUnlocked));

    // Control register fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {oscCal_r, unlock_r, toMask_r} <= CTRL_RST[7:4];
        end else if (softReset) begin
            {oscCal_r, unlock_r, toMask_r} <= CTRL_RST[7:4];
        end else if (restart) begin
            {oscCal_r, unlock_r, toMask_r} <= {oscCal_r, unlock_r, toMask_r};
        end else if (ctrlWrite) begin
            oscCal_r <= regWdata[CTRL_CAL_BIT];
            unlock_r <= regWdata[CTRL_UNL_HI:CTRL_UNL_LO];
            toMask_r <= regWdata[CTRL_MASK_BIT];
        end
    end

    // Valid flag: clear by hardware wins over host set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgValid_r <= 1'b0;
        end else if (softReset || restart) begin
            cfgValid_r <= 1'b0;
        end else if (wakeUpEvent || cfgChange) begin
            cfgValid_r <= 1'b0;
        end else if (ctrlWrite) begin
            cfgValid_r <= regWdata[CTRL_VAL_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quanta_r <= QUANTA_RST;
            sample_r <= SAMPLE_RST;
        end else if (softReset) begin
            quanta_r <= QUANTA_RST;
            sample_r <= SAMPLE_RST;
        end else if (regWrite && regAddr == ADDR_QUANTA) begin
            quanta_r <= regWdata;
        end else if (regWrite && regAddr == ADDR_SAMPLE) begin
            sample_r <= regWdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            option_r <= OPTION_RST;
        end else if (softReset) begin
            option_r <= OPTION_RST;
        end else if (regWrite && regAddr == ADDR_OPTION && trimUnlocked) begin
            option_r <= regWdata;
        end
    end

    // Time-out flag follows events only while wake is enabled; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toFlag_r <= 1'b0;
        end else if (selectiveWakeEnable && modeNormalOrStop && busTimeoutEvent) begin
            toFlag_r <= 1'b1;
        end else if (softReset) begin
            toFlag_r <= 1'b0;
        end else if (selectiveWakeEnable && !busTimeoutEvent) begin
            toFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= toMask_r && selectiveWakeEnable && modeNormalOrStop
                     && busTimeoutEvent;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txSync1_r <= 1'b0;
            txSync2_r <= 1'b0;
        end else begin
            txSync1_r <= busTransmitInput;
            txSync2_r <= txSync1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdLocal_r <= 8'h00;
        end else begin
            case (regAddr)
                ADDR_CTRL:   rdLocal_r <= {oscCal_r, unlock_r, toMask_r, 3'h0, cfgValid_r};
                ADDR_QUANTA: rdLocal_r <= quanta_r;
                ADDR_SAMPLE: rdLocal_r <= {2'h0, sample_r};
                ADDR_OPTION: rdLocal_r <= option_r;
                default:     rdLocal_r <= 8'h00;
            endcase
        end
    end

    assign trimUnlocked        = unlock_r == UNLOCK_CODE;
    assign oscCalActive        = oscCal_r && trimUnlocked;
    assign oscTrimRef          = oscCalActive & txSync2_r;
    assign selectiveWakeEnable = cfgValid_r;
    assign busTimeoutFlag      = toFlag_r;
    assign interrupt_out_n     = ~irq_r;
    assign quantaPerBit        = quanta_r;
    assign samplePointFraction = sample_r;
    assign identExpected       = {identWord[31:8], identWord[6:2]};
    assign identStandard       = identExpected[28:18];
    assign remoteRequest       = identWord[1];
    assign identExtended       = identWord[0];
    assign wakeOptionReg       = option_r;

    // Identifier bytes come registered from the bank, zero elsewhere
    assign regRdata = rdLocal_r | idBus.rdata;

    valid_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wakeUpEvent || cfgChange) |=> !cfgValid_r)
        else $error("valid flag not cleared");
    option_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_OPTION && !trimUnlocked && !softReset)
        |=> $stable(option_r))
        else $error("locked option write took effect");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !interrupt_out_n |-> $past(toMask_r) && $past(cfgValid_r))
        else $error("interrupt without mask or enable");
    irq_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (toMask_r && cfgValid_r && modeNormalOrStop && busTimeoutEvent) |=> !interrupt_out_n)
        else $error("time-out interrupt missing");
    ctrl_resv_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(regAddr) == ADDR_CTRL |-> regRdata[3:1] == 3'h0)
        else $error("reserved control bits not zero");
    restart_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (restart && !softReset) |=> $stable(toMask_r) && $stable(unlock_r) && !cfgValid_r)
        else $error("restart handling wrong");
    cal_unlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        oscCalActive |-> unlock_r == 2'h3 && oscCal_r)
        else $error("calibration active while locked");
    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        softReset |=> quanta_r == 8'ha0 && sample_r == 6'h33)
        else $error("timing reset values wrong");

    // Control writes and lock handling
    cal_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && !softReset && !restart)
        |=> oscCal_r == $past(regWdata[CTRL_CAL_BIT]))
        else $error("calibration bit not written");
    unlock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && !softReset && !restart
         && regWdata[CTRL_UNL_HI:CTRL_UNL_LO] == UNLOCK_CODE)
        |=> trimUnlocked)
        else $error("unlock code not taken");
    relock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && !softReset && !restart
         && regWdata[CTRL_UNL_HI:CTRL_UNL_LO] != UNLOCK_CODE)
        |=> !trimUnlocked)
        else $error("other unlock value left unlocked");
    option_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_OPTION && trimUnlocked && !softReset)
        |=> wakeOptionReg == $past(regWdata))
        else $error("unlocked option write lost");
    mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && !softReset && !restart)
        |=> toMask_r == $past(regWdata[CTRL_MASK_BIT]))
        else $error("mask bit not written");
    valid_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrlWrite && regWdata[CTRL_VAL_BIT] && !wakeUpEvent && !softReset && !restart)
        |=> selectiveWakeEnable)
        else $error("valid flag not set by host");
    soft_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
        softReset
        |=> {oscCal_r, unlock_r, toMask_r, cfgValid_r} == 4'h0)
        else $error("control not cleared by soft reset");

    // Interrupt and time-out flag gating
    irq_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
        !toMask_r
        |=> interrupt_out_n)
        else $error("masked time-out raised interrupt");
    irq_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        !modeNormalOrStop
        |=> interrupt_out_n)
        else $error("interrupt outside normal or stop");
    irq_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cfgValid_r
        |=> interrupt_out_n)
        else $error("interrupt with wake disabled");
    flag_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!cfgValid_r && !softReset)
        |=> $stable(busTimeoutFlag))
        else $error("time-out flag moved while disabled");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgValid_r && modeNormalOrStop && busTimeoutEvent)
        |=> busTimeoutFlag)
        else $error("time-out flag not raised");

    // Timing and identifier storage
    quanta_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_QUANTA && !softReset)
        |=> quantaPerBit == $past(regWdata))
        else $error("quanta write lost");
    sample_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_SAMPLE && !softReset)
        |=> samplePointFraction == $past(regWdata[5:0]))
        else $error("sample point write lost");
    sample_resv_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(regAddr) == ADDR_SAMPLE
        |-> regRdata[7:6] == 2'h0)
        else $error("reserved sample bits not zero");
    ident_resv_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(regAddr) == ADDR_ID_LOW
        |-> !regRdata[7])
        else $error("reserved identifier bit not zero");
    ident_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(regAddr) == ADDR_ID_HIGH && !$past(regWrite) && !$past(softReset))
        |-> regRdata == identExpected[28:21])
        else $error("identifier high byte read wrong");
    ident_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_ID_LOW && !softReset && !restart)
        |=> identExpected[4:0] == $past(regWdata[6:2]))
        else $error("identifier low bits misplaced");
    ext_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWrite && regAddr == ADDR_ID_LOW && !softReset && !restart)
        |=> identExtended == $past(regWdata[0]))
        else $error("extension bit not written");
endmodule

// file: testbench/swc_host_ref.sv
/*
 * Host-side source for the oscillator trim reference pin.
 * Assumes the bench raises refOn only while calibration is wanted.
 */
`timescale 1ns/10ps
module swc_host_ref (
    input  wire logic       clk,
    input  wire logic       refOn,
    output logic      [2:0] phase,
    output logic            refPin
);
    initial phase = 3'h0;
    // Square wave, four clocks per level
    always @(negedge clk) begin
        phase <= refOn ? phase + 3'h1 : 3'h0;
    end
    // Idle recessive high
    assign refPin = refOn ? phase[2] : 1'b1;
endmodule

// file: testbench/swc_config_tb.sv
/*
 * Self-checking bench for the selective-wake configuration bank.
 * Assumes one-cycle write strobes and read data one cycle after address.
 */
`timescale 1ns/10ps
module swc_config_tb;
    import swc_pkg::*;
    logic        clk, rst_n, softReset, restart, regWrite, wakeUpEvent;
    logic        busTimeoutEvent, modeNormalOrStop, busTransmitInput, refOn, rdPend;
    logic        oscCalActive, oscTrimRef, trimUnlocked, selectiveWakeEnable;
    logic        busTimeoutFlag, interrupt_out_n, remoteRequest, identExtended;
    logic [6:0]  regAddr;
    logic [7:0]  regWdata, regRdata, quantaPerBit, wakeOptionReg, r;
    logic [5:0]  samplePointFraction;
    logic [28:0] identExpected;
    logic [10:0] identStandard;
    logic [2:0]  phase;
    logic [7:0]  id [4];
    logic [7:0]  expQ [$];
    int          error_cnt, n_checks;

    swc_config swc_config_i (.clk(clk), .rst_n(rst_n), .softReset(softReset),
        .restart(restart), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .wakeUpEvent(wakeUpEvent), .busTimeoutEvent(busTimeoutEvent),
        .modeNormalOrStop(modeNormalOrStop), .busTransmitInput(busTransmitInput),
        .oscCalActive(oscCalActive), .oscTrimRef(oscTrimRef), .trimUnlocked(trimUnlocked),
        .selectiveWakeEnable(selectiveWakeEnable), .busTimeoutFlag(busTimeoutFlag),
        .interrupt_out_n(interrupt_out_n), .quantaPerBit(quantaPerBit),
        .samplePointFraction(samplePointFraction), .identExpected(identExpected),
        .identStandard(identStandard), .remoteRequest(remoteRequest),
        .identExtended(identExtended), .wakeOptionReg(wakeOptionReg));
    swc_host_ref swc_host_ref_i (.clk(clk), .refOn(refOn), .phase(phase),
        .refPin(busTransmitInput));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr  = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask

    // Note expected read data; the monitor takes it off the queue
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        rdPend = 1'b1;
        expQ.push_back(e);
        @(negedge clk);
        rdPend = 1'b0;
    endtask

    always @(posedge clk) begin
        if (rdPend) begin
            chk({24'h0, regRdata}, {24'h0, expQ.pop_front()});
        end
    end

    // One-cycle time-out, then count low interrupt and raised flag cycles
    task automatic pulseTo(input int expLow, input int expFlag);
        int lows;
        int hits;
        lows = 0;
        hits = 0;
        @(negedge clk);
        busTimeoutEvent = 1'b1;
        repeat (4) begin
            @(negedge clk);
            if (interrupt_out_n === 1'b0) lows++;
            if (busTimeoutFlag === 1'b1) hits++;
            busTimeoutEvent = 1'b0;
        end
        chk(lows, expLow);
        chk(hits, expFlag);
    endtask

    initial begin
        #200us;
        error_cnt++;
        $display("unexpected at %0t: got %h exp %h", $time, 0, 1);
        results();
    end

    initial begin
        {rst_n, softReset, restart, regWrite, wakeUpEvent, busTimeoutEvent} = 6'h00;
        {refOn, rdPend, regAddr, regWdata, modeNormalOrStop} = 18'h1;
        error_cnt = 0;
        n_checks = 0;
        void'($urandom(35));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_SAMPLE, {2'h0, SAMPLE_RST});
        chk(identExpected, 0);
        $display("test reset values done");
        r = 8'($urandom);
        wr(ADDR_QUANTA, r);
        rd(ADDR_QUANTA, r);
        chk(quantaPerBit, r);
        wr(ADDR_SAMPLE, 8'hff);
        rd(ADDR_SAMPLE, SAMPLE_MASK);
        chk(samplePointFraction, 6'h3f);
        $display("test bit timing done");
        for (int u = 0; u < 4; u++) begin
            wr(ADDR_CTRL, {1'b1, 2'(u), 5'h0e});
            chk(trimUnlocked, u == 3);
            chk(oscCalActive, u == 3);
        end
        rd(ADDR_CTRL, 8'he0);
        wr(ADDR_OPTION, 8'h5a);
        chk(wakeOptionReg, 8'h5a);
        refOn = 1'b1;
        repeat (16) begin
            @(negedge clk);
            if (phase[1:0] == 2'h3) chk(oscTrimRef, busTransmitInput);
        end
        refOn = 1'b0;
        wr(ADDR_CTRL, 8'h40);
        chk(oscCalActive, 0);
        chk(oscTrimRef, 0);
        wr(ADDR_OPTION, 8'h11);
        rd(ADDR_OPTION, 8'h5a);
        $display("test unlock done");
        for (int i = 0; i < 4; i++) begin
            id[i] = 8'($urandom);
            if (i == 3) {id[i][7], id[i][1]} = 2'b10;
            wr(7'(ADDR_ID_HIGH + i), id[i]);
        end
        chk(identExpected, {id[0], id[1], id[2], id[3][6:2]});
        chk(identStandard, {id[0], id[1][7:5]});
        chk(remoteRequest, 0);
        chk(identExtended, id[3][0]);
        rd(ADDR_ID_HIGH, id[0]);
        wr(ADDR_ID_LOW, id[3] ^ 8'h01);
        chk(identExtended, !id[3][0]);
        rd(ADDR_ID_LOW, (id[3] ^ 8'h01) & IDLOW_MASK);
        $display("test identifier done");
        wr(ADDR_CTRL, 8'h10);
        pulseTo(0, 0);
        chk(busTimeoutFlag, 0);
        wr(ADDR_CTRL, 8'h11);
        chk(selectiveWakeEnable, 1);
        modeNormalOrStop = 1'b0;
        pulseTo(0, 0);
        modeNormalOrStop = 1'b1;
        pulseTo(1, 1);
        wr(ADDR_CTRL, 8'h01);
        pulseTo(0, 1);
        wr(ADDR_QUANTA, 8'h7f);
        chk(selectiveWakeEnable, 0);
        wr(ADDR_CTRL, 8'h01);
        chk(selectiveWakeEnable, 1);
        @(negedge clk);
        wakeUpEvent = 1'b1;
        @(negedge clk);
        wakeUpEvent = 1'b0;
        chk(selectiveWakeEnable, 0);
        $display("test valid flag done");
        wr(ADDR_CTRL, 8'hf1);
        @(negedge clk);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        rd(ADDR_CTRL, 8'hf0);
        @(negedge clk);
        softReset = 1'b1;
        @(negedge clk);
        softReset = 1'b0;
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_QUANTA, QUANTA_RST);
        wr(ADDR_QUANTA, 8'h12);
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rd(ADDR_QUANTA, QUANTA_RST);
        $display("test resets done");
        results();
    end
endmodule
